// ### rtl/jtp_tap.sv
// jtp_tap: boundary-scan test port controller with its instruction,
// bypass, identification and boundary registers, and a FIFO that
// carries boundary update words to the user side, dropping any that arrive while it is full.
// assumes tck/tms/tdi and the pin inputs are asynchronous to CLK and that
// the test clock runs well below CLK/4 so both its edges are seen.
`timescale 1ns/1ps
`default_nettype none

module jtp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // both pointers wrap the same way, so the step lives in one place
  function automatic logic [AW-1:0] bump(logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } jtp_fifo_st_t;

  jtp_fifo_st_t r;
  jtp_fifo_st_t nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt = r;
    if (push) begin
      nxt.wp = bump(r.wp);
    end
    if (pop) begin
      nxt.rp = bump(r.rp);
    end
    if (push && !pop) begin
      nxt.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  // storage carries no reset; only the pointers and the count decide what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[r.wp] <= in_data;
    end
  end
endmodule : jtp_fifo

module jtp_tap #(
  parameter logic [jtp_pkg::ID_W-1:0] ID_VALUE = jtp_pkg::ID_DEFAULT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // test port pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  // boundary cells toward the device core and pins
  input wire logic [jtp_pkg::BSR_W-1:0] BSR_PIN_IN,
  output logic [jtp_pkg::BSR_W-1:0] BSR_OUT,
  output logic BSR_DRIVE,
  output logic TEST_RESET,
  output logic [jtp_pkg::IR_W-1:0] IR_CURRENT,
  // stream of boundary update words
  output logic UPD_VALID,
  output logic [jtp_pkg::BSR_W-1:0] UPD_DATA,
  input wire logic UPD_READY,
  output logic UPD_ROOM
);
  typedef struct packed {
    jtp_pkg::jtp_pins_t s1;
    jtp_pkg::jtp_pins_t s2;
    logic tck_d;
    logic [jtp_pkg::BSR_W-1:0] pin_s1;
    logic [jtp_pkg::BSR_W-1:0] pin_s2;
    jtp_pkg::jtp_state_t st;
    logic [jtp_pkg::IR_W-1:0] ir_sh;
    logic [jtp_pkg::IR_W-1:0] ir;
    logic byp;
    logic [jtp_pkg::ID_W-1:0] id_sh;
    logic [jtp_pkg::BSR_W-1:0] bsr_sh;
    logic [jtp_pkg::BSR_W-1:0] bsr_lat;
    jtp_pkg::jtp_tdo_t out;
  } jtp_tap_st_t;

  jtp_tap_st_t r;
  jtp_tap_st_t nxt;
  logic rise;
  logic fall;
  logic bsr_sel;
  logic push;

  function automatic logic is_bsr(logic [jtp_pkg::IR_W-1:0] code);
    return (code == jtp_pkg::IR_EXTEST) || (code == jtp_pkg::IR_SAMPLE);
  endfunction : is_bsr

  // undefined codes fall through to bypass
  function automatic logic is_id(logic [jtp_pkg::IR_W-1:0] code);
    return code == jtp_pkg::IR_IDCODE;
  endfunction : is_id

  // serial output of whichever register sits on the path
  function automatic logic tdo_pick(
    jtp_pkg::jtp_state_t s,
    logic [jtp_pkg::IR_W-1:0] code,
    logic ir0,
    logic bsr0,
    logic id0,
    logic byp0
  );
    if (s == jtp_pkg::ST_SH_IR) begin
      return ir0;
    end
    if (is_bsr(code)) begin
      return bsr0;
    end
    if (is_id(code)) begin
      return id0;
    end
    return byp0;
  endfunction : tdo_pick

  function automatic jtp_pkg::jtp_state_t next_st(jtp_pkg::jtp_state_t s, logic tms);
    next_st = jtp_pkg::ST_RESET;
    unique case (s)
      jtp_pkg::ST_RESET: begin
        next_st = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
      end
      jtp_pkg::ST_IDLE: begin
        next_st = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      end
      jtp_pkg::ST_SEL_DR: begin
        next_st = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      end
      jtp_pkg::ST_CAP_DR: begin
        next_st = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      end
      jtp_pkg::ST_SH_DR: begin
        next_st = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      end
      jtp_pkg::ST_EX1_DR: begin
        next_st = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
      end
      jtp_pkg::ST_PAU_DR: begin
        next_st = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
      end
      jtp_pkg::ST_EX2_DR: begin
        next_st = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
      end
      jtp_pkg::ST_SEL_IR: begin
        next_st = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
      end
      jtp_pkg::ST_CAP_IR: begin
        next_st = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      end
      jtp_pkg::ST_SH_IR: begin
        next_st = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      end
      jtp_pkg::ST_EX1_IR: begin
        next_st = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
      end
      jtp_pkg::ST_PAU_IR: begin
        next_st = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
      end
      jtp_pkg::ST_EX2_IR: begin
        next_st = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
      end
      jtp_pkg::ST_UPD_DR, jtp_pkg::ST_UPD_IR: begin
        next_st = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      end
    endcase
  endfunction : next_st

  // edges come from the second and third stage, never the first
  assign rise = r.s2.tck & ~r.tck_d;
  assign fall = ~r.s2.tck & r.tck_d;
  assign bsr_sel = is_bsr(r.ir);
  assign push = fall && (r.st == jtp_pkg::ST_UPD_DR) && bsr_sel;

  always_comb begin
    nxt = r;
    nxt.s1 = '{tck: TCK, tms: TMS, tdi: TDI};
    nxt.s2 = r.s1;
    nxt.tck_d = r.s2.tck;
    nxt.pin_s1 = BSR_PIN_IN;
    nxt.pin_s2 = r.pin_s1;
    // pause, exit and select states fall through with every shift register held
    if (rise) begin
      unique case (r.st)
        jtp_pkg::ST_CAP_DR: begin
          if (bsr_sel) begin
            nxt.bsr_sh = r.pin_s2;
          end else if (is_id(r.ir)) begin
            nxt.id_sh = ID_VALUE;
          end else begin
            nxt.byp = 1'b0;
          end
        end
        jtp_pkg::ST_SH_DR: begin
          if (bsr_sel) begin
            nxt.bsr_sh = {r.s2.tdi, r.bsr_sh[jtp_pkg::BSR_W-1:1]};
          end else if (is_id(r.ir)) begin
            nxt.id_sh = {r.s2.tdi, r.id_sh[jtp_pkg::ID_W-1:1]};
          end else begin
            nxt.byp = r.s2.tdi;
          end
        end
        jtp_pkg::ST_CAP_IR: nxt.ir_sh = jtp_pkg::IR_CAPTURE_VAL;
        jtp_pkg::ST_SH_IR: nxt.ir_sh = {r.s2.tdi, r.ir_sh[jtp_pkg::IR_W-1:1]};
        jtp_pkg::ST_RESET: begin
        end
        jtp_pkg::ST_IDLE: begin
        end
        jtp_pkg::ST_SEL_DR: begin
        end
        jtp_pkg::ST_EX1_DR: begin
        end
        jtp_pkg::ST_PAU_DR: begin
        end
        jtp_pkg::ST_EX2_DR: begin
        end
        jtp_pkg::ST_UPD_DR: begin
        end
        jtp_pkg::ST_SEL_IR: begin
        end
        jtp_pkg::ST_EX1_IR: begin
        end
        jtp_pkg::ST_PAU_IR: begin
        end
        jtp_pkg::ST_EX2_IR: begin
        end
        jtp_pkg::ST_UPD_IR: begin
        end
      endcase
      nxt.st = next_st(r.st, r.s2.tms);
    end
    if (fall) begin
      if (push) begin
        nxt.bsr_lat = r.bsr_sh;
      end
      if (r.st == jtp_pkg::ST_UPD_IR) begin
        nxt.ir = r.ir_sh;
      end
      // tdo moves on the falling edge so the tester samples it stable
      nxt.out.tdo_oe = (r.st == jtp_pkg::ST_SH_DR) || (r.st == jtp_pkg::ST_SH_IR);
      nxt.out.tdo = tdo_pick(r.st, r.ir, r.ir_sh[0], r.bsr_sh[0], r.id_sh[0], r.byp);
    end
    if (r.st == jtp_pkg::ST_RESET) begin
      nxt.ir = jtp_pkg::IR_RESET_VAL;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      r <= '0;
      r.st <= jtp_pkg::ST_RESET;
      r.ir <= jtp_pkg::IR_RESET_VAL;
      r.ir_sh <= jtp_pkg::IR_CAPTURE_VAL;
      r.bsr_lat <= jtp_pkg::BSR_RESET_VAL;
    end else begin
      r <= nxt;
    end
  end

  // the update stream never stalls the scan; a full buffer shows on UPD_ROOM
  jtp_fifo #(
    .WIDTH(jtp_pkg::BSR_W),
    .DEPTH(jtp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(push),
    .in_data(r.bsr_sh),
    .in_ready(UPD_ROOM),
    .out_valid(UPD_VALID),
    .out_data(UPD_DATA),
    .out_ready(UPD_READY)
  );

  assign TDO = r.out.tdo;
  assign TDO_OE = r.out.tdo_oe;
  assign BSR_OUT = r.bsr_lat;
  assign BSR_DRIVE = (r.ir == jtp_pkg::IR_EXTEST) && (r.st != jtp_pkg::ST_RESET);
  assign TEST_RESET = (r.st == jtp_pkg::ST_RESET);
  assign IR_CURRENT = r.ir;
endmodule : jtp_tap

`default_nettype wire

// ### rtl/jtp_pkg.sv
// jtp_pkg: constants, states and carriers for the test port controller.
// assumes one 40 MHz system clock; the test clock is sampled, not used as a clock.
package jtp_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 98;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_STAGES = 2;
  localparam int TMS_RESET_EDGES = 5;
  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h6;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h4;
  localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDCODE;
  // arbitrary identification value; bit 0 stays set as the register demands
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_0001;
  localparam logic [BSR_W-1:0] BSR_RESET_VAL = '0;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_state_t;

  // pins as seen after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_pins_t;

  // serial answer toward the tester
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jtp_tdo_t;
endpackage : jtp_pkg

// ### tb/jtp_tap_sva.sv
// jtp_tap_sva: port checker for the test port controller.
// assumes the tester moves pins at CLK edges, TCK halves of 4 CLK.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_sva (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // test port
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDO_OE,
  // results
  input wire logic [jtp_pkg::BSR_W-1:0] BSR_OUT,
  input wire logic TEST_RESET,
  input wire logic [jtp_pkg::IR_W-1:0] IR_CURRENT,
  input wire logic UPD_VALID,
  input wire logic [jtp_pkg::BSR_W-1:0] UPD_DATA
);
  logic tck_r;
  logic [2:0] hi_r;
  // counts raw rises with TMS high, saturating
  always_ff @(posedge CLK) begin
    tck_r <= TCK;
    if (!NRST || (TCK && !tck_r && !TMS)) hi_r <= 3'h0;
    else if (TCK && !tck_r && hi_r != 3'h7) hi_r <= hi_r + 3'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  five_high_a: assert property (TCK && !tck_r && TMS && hi_r == 3'h4 |-> ##[1:6] TEST_RESET)
    else $error("no reset after five high");
  stay_reset_a: assert property (TEST_RESET && TCK && !tck_r && TMS |-> TEST_RESET [*8])
    else $error("reset left with mode high");
  boot_state_a: assert property ($rose(NRST) |-> TEST_RESET && !UPD_VALID)
    else $error("bad state after reset");
  idcode_held_a: assert property (TEST_RESET ##1 TEST_RESET |-> IR_CURRENT == 3'h6)
    else $error("instruction not identification");
  idle_exit_a: assert property ($fell(TEST_RESET) |-> !$past(TMS, 3))
    else $error("reset left with mode high");
  oe_fall_a: assert property ($changed(TDO_OE) |-> !$past(TCK) && !$past(TCK, 2))
    else $error("enable moved off a fall");
  ir_fall_a: assert property ($changed(IR_CURRENT) && !TEST_RESET && !$past(TEST_RESET)
    |-> !$past(TCK) && !$past(TCK, 2))
    else $error("instruction moved off a fall");
  bsr_fall_a: assert property ($changed(BSR_OUT) |-> !$past(TCK) && !$past(TCK, 2))
    else $error("latch moved off a fall");
  push_word_a: assert property ($rose(UPD_VALID) |-> UPD_DATA == BSR_OUT)
    else $error("pushed word differs");
endmodule : jtp_tap_sva
bind jtp_tap jtp_tap_sva u_sva (.CLK(CLK), .NRST(NRST), .TCK(TCK), .TMS(TMS),
  .TDO_OE(TDO_OE), .BSR_OUT(BSR_OUT), .TEST_RESET(TEST_RESET),
  .IR_CURRENT(IR_CURRENT), .UPD_VALID(UPD_VALID), .UPD_DATA(UPD_DATA));
`default_nettype wire

// ### tb/jtp_tester.sv
// jtp_tester: boundary-scan tester model on the test port pins.
// assumes each step is entered just after a clk edge.
`timescale 1ns/1ps
`default_nettype none
module jtp_tester (
  // clock
  input wire logic clk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial tck = 1'b0;
  initial tms = 1'b1;
  initial tdi = 1'b0;
  // tck rests high between steps; answer taken after the rise, settled since the fall
  task automatic step(input logic m, input logic d, output logic o);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    @(posedge clk);
    o = tdo;
  endtask : step
  // tck parked low, tms high, so a reset release sees no false edge
  task automatic park;
    tck <= 1'b0;
    tms <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : park
endmodule : jtp_tester
`default_nettype wire

// ### tb/test_jtp_tap.sv
// test_jtp_tap: scan walks compared with a queue model of the port.
// assumes the default identification value.
`timescale 1ns/1ps
`default_nettype none
module test_jtp_tap;
  localparam int W = jtp_pkg::BSR_W;
  localparam int LO [16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
  localparam int HI [16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic upd_ready = 1'b0;
  logic hold = 1'b0;
  logic [W-1:0] pins = '0;
  wire tck, tms, tdi, tdo, oe, tr, vld, room, drv;
  wire [2:0] irc;
  wire [W-1:0] bout, udata;
  int st, n_errors, checks;
  logic [2:0] ir;
  logic [15:0] r = 16'he2e6;
  logic q[$];
  logic [W-1:0] fq[$];
  logic [W-1:0] wd = '0;
  initial forever #12.5 clk = ~clk;
  jtp_tap uut (.CLK(clk), .NRST(nrst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE(oe), .BSR_PIN_IN(pins), .BSR_OUT(bout), .BSR_DRIVE(drv), .TEST_RESET(tr),
    .IR_CURRENT(irc), .UPD_VALID(vld), .UPD_DATA(udata), .UPD_READY(upd_ready),
    .UPD_ROOM(room));
  jtp_tester u_tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic cmp(input logic [W-1:0] g, input logic [W-1:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // one test clock: fall actions, compare, rise actions
  task automatic tap(input logic m, input logic d);
    logic o;
    r = lfsr(r);
    if (st == 0) ir = 3'h6;
    if (st == 15) ir = {q[2], q[1], q[0]};
    if (st == 8 && ir inside {3'h0, 3'h4}) begin
      for (int i = 0; i < W; i++) wd[i] = q[i];
      if (fq.size() < jtp_pkg::FIFO_DEPTH) fq.push_back(wd);
    end
    pins <= W'({7{r}});
    upd_ready <= !hold && (r[0] || r[1]);
    u_tst.step(m, d, o);
    cmp(tr, st == 0);
    cmp(drv, ir == 3'h0 && st != 0);
    cmp(oe, st inside {4, 11});
    if (st inside {4, 11}) cmp(o, q[0]);
    cmp(irc, ir);
    cmp(bout, wd);
    case (st)
      3: begin
        q.delete();
        if (ir inside {3'h0, 3'h4}) for (int i = 0; i < W; i++) q.push_back(pins[i]);
        else if (ir == 3'h6) for (int i = 0; i < 32; i++) q.push_back(jtp_pkg::ID_DEFAULT[i]);
        else q.push_back(1'b0);
      end
      10: q = '{1'b0, 1'b0, 1'b1};
      4, 11: begin
        void'(q.pop_front());
        q.push_back(d);
      end
      default: ;
    endcase
    st = m ? HI[st] : LO[st];
    repeat (3) @(posedge clk);
  endtask : tap
  task automatic walk(input int n, input logic [127:0] m, input logic [127:0] d);
    for (int i = 0; i < n; i++) tap(m[i], d[i]);
  endtask : walk
  // words leave in push order
  always @(posedge clk) begin
    if (nrst && vld && upd_ready) cmp(udata, fq.pop_front());
  end
  initial begin
    st = 0;
    ir = 3'h6;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int c = 7; c >= 0; c--) walk(121, 128'h00d2_0000_0000_0000_0000_0000_0000_0e86,
      {r, 104'h0, c[2:0], 5'h0});
    hold = 1'b1;
    upd_ready <= 1'b0;
    repeat (34) walk(5, 128'hd, '0);
    cmp(room, 1'b0);
    hold = 1'b0;
    walk(40, '0, '0);
    cmp(vld, 1'b0);
    repeat (3) begin
      walk(100, {8{r}}, {8{~r}});
      hold = 1'b1;
      upd_ready <= 1'b0;
      u_tst.park();
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      hold = 1'b0;
      st = 0;
      ir = 3'h6;
      wd = '0;
      fq.delete();
      walk(100, {8{r}}, {8{r}});
      walk(7, 128'h3f, '0);
    end
    wrap_up();
  end
  initial begin
    #1_000_000;
    n_errors++;
    wrap_up();
  end
endmodule : test_jtp_tap
`default_nettype wire
